// file: cvt_regs.sv
// APB register bank: calibration vector port, fuse-loaded trims and dither control.
// Assumes fuse values are static from reset and the stop indication is asynchronous.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module cvt_regs (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cvt_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fuse storage and calibration engine
   input wire cvt_pkg::cvt_trim_type fuse_trim,
   input wire logic calibration_stopped_indication,
   output logic cal_access_enabled,
   output logic cal_data_valid,
   // Trim and dither outputs
   output cvt_pkg::cvt_trim_type trim_out,
   output logic dither_enable_bit,
   output logic dither_amplitude_select,
   output logic rounding_error_select
);

   cvt_pkg::cvt_state_type s;
   cvt_pkg::cvt_state_type next_s;
   logic [9:0] idx;
   logic [7:0] vec_rdata;
   logic vec_we;
   logic done;
   logic is_port;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic is_mapped(input logic [9:0] i);
      unique case (i)
         cvt_pkg::IDX_ACCESS_OPTIONS, cvt_pkg::IDX_CAL_STATUS,
         cvt_pkg::IDX_CAL_ENABLE, cvt_pkg::IDX_CAL_PORT,
         cvt_pkg::IDX_GAIN_A, cvt_pkg::IDX_GAIN_B,
         cvt_pkg::IDX_REFERENCE, cvt_pkg::IDX_TERM_A,
         cvt_pkg::IDX_TERM_B, cvt_pkg::IDX_DITHER: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // Read mux; reserved and unused bits return zero
   function automatic logic [31:0] reg_read(input logic [9:0] i,
                                            input cvt_pkg::cvt_state_type st,
                                            input logic [7:0] vec);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (i)
         cvt_pkg::IDX_ACCESS_OPTIONS: r[cvt_pkg::HOLD_BIT] = st.addr_hold;
         cvt_pkg::IDX_CAL_STATUS: begin
            r[cvt_pkg::STAT_STOP_BIT] = st.stop_sync;
            r[cvt_pkg::STAT_VALID_BIT] = st.valid;
            r[cvt_pkg::STAT_INDEX_LSB +: cvt_pkg::INDEX_W] = st.index;
         end
         cvt_pkg::IDX_CAL_ENABLE: r[cvt_pkg::ENABLE_BIT] = st.cal_en;
         cvt_pkg::IDX_CAL_PORT: r[7:0] = st.cal_en ? vec : 8'h00;
         cvt_pkg::IDX_GAIN_A: r[7:0] = st.trim.gain_a;
         cvt_pkg::IDX_GAIN_B: r[7:0] = st.trim.gain_b;
         cvt_pkg::IDX_REFERENCE: r[3:0] = st.trim.ref_trim;
         cvt_pkg::IDX_TERM_A: r[7:0] = st.trim.term_a;
         cvt_pkg::IDX_TERM_B: r[7:0] = st.trim.term_b;
         cvt_pkg::IDX_DITHER: r[2:0] = st.trim.dither;
         default: r = 32'h0000_0000;
      endcase
      reg_read = r;
   endfunction

   // ------------------------------------------------------------
   // Vector store
   // ------------------------------------------------------------
   cvt_cal_store #(
      .DEPTH(cvt_pkg::VEC_LEN),
      .AW(cvt_pkg::INDEX_W)
   ) u_store (
      .pclk(pclk),
      .wr_en(vec_we),
      .addr(s.index),
      .wdata(pwdata[7:0]),
      .rdata(vec_rdata)
   );

   assign idx = paddr[cvt_pkg::ADDR_W-1:2];
   assign is_port = (idx == cvt_pkg::IDX_CAL_PORT);
   // Completion edge of an access; pready is high throughout the ack phase
   assign done = (s.phase == cvt_pkg::PH_ACK) && psel && penable;
   assign vec_we = done && pwrite && pstrb[0] && is_port && !s.pslverr;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      // Stop indication crosses in from the engine through two flops
      next_s.stop_meta = calibration_stopped_indication;
      next_s.stop_sync = s.stop_meta;

      // Fuse copy on the first edge after reset release
      if (!s.loaded) begin
         next_s.trim = fuse_trim;
         next_s.loaded = 1'b1;
      end

      // APB handshake
      unique case (s.phase)
         cvt_pkg::PH_IDLE: begin
            if (psel && !penable) begin
               next_s.prdata = reg_read(idx, s, vec_rdata);
               next_s.pslverr = !is_mapped(idx) || (is_port && !s.cal_en);
               // Without address hold a port access costs one wait state
               if (is_port && s.cal_en && !s.addr_hold) begin
                  next_s.phase = cvt_pkg::PH_WAIT;
               end else begin
                  next_s.phase = cvt_pkg::PH_ACK;
                  next_s.pready = 1'b1;
               end
            end
         end
         cvt_pkg::PH_WAIT: begin
            next_s.phase = cvt_pkg::PH_ACK;
            next_s.pready = 1'b1;
         end
         cvt_pkg::PH_ACK: begin
            if (psel && penable) begin
               next_s.phase = cvt_pkg::PH_IDLE;
               next_s.pready = 1'b0;
               next_s.pslverr = 1'b0;
               next_s.prdata = 32'h0000_0000;
            end
         end
      endcase

      // Register writes take effect only at the completion edge
      if (done && pwrite && pstrb[0] && !s.pslverr) begin
         unique case (idx)
            cvt_pkg::IDX_ACCESS_OPTIONS: next_s.addr_hold = pwdata[cvt_pkg::HOLD_BIT];
            cvt_pkg::IDX_CAL_ENABLE: next_s.cal_en = pwdata[cvt_pkg::ENABLE_BIT];
            cvt_pkg::IDX_GAIN_A: next_s.trim.gain_a = pwdata[7:0];
            cvt_pkg::IDX_GAIN_B: next_s.trim.gain_b = pwdata[7:0];
            cvt_pkg::IDX_REFERENCE: next_s.trim.ref_trim = pwdata[3:0];
            cvt_pkg::IDX_TERM_A: next_s.trim.term_a = pwdata[7:0];
            cvt_pkg::IDX_TERM_B: next_s.trim.term_b = pwdata[7:0];
            cvt_pkg::IDX_DITHER: next_s.trim.dither = pwdata[2:0];
            default: next_s = next_s;
         endcase
      end

      // Vector walk and validity
      if (done && is_port && !s.pslverr) begin
         next_s.index = (s.index == cvt_pkg::VEC_LAST) ? cvt_pkg::INDEX_FIRST
                        : 10'(s.index + 10'h001);
         if (!s.stop_sync) begin
            next_s.valid = 1'b0;
         end else if (pwrite) begin
            next_s.valid = (s.index == cvt_pkg::VEC_LAST);
         end
      end
      // Leaving access mode mid-vector abandons the sequence
      if (!next_s.cal_en) begin
         next_s.index = cvt_pkg::INDEX_FIRST;
         if (s.index != cvt_pkg::INDEX_FIRST) begin
            next_s.valid = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{phase: cvt_pkg::PH_IDLE, trim: cvt_pkg::TRIM_RESET, default: '0};
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all straight from state
   // ------------------------------------------------------------
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign cal_access_enabled = s.cal_en;
   assign cal_data_valid = s.valid;
   assign trim_out = s.trim;
   assign dither_enable_bit = s.trim.dither[cvt_pkg::DITH_EN_BIT];
   assign dither_amplitude_select = s.trim.dither[cvt_pkg::DITH_AMP_BIT];
   assign rounding_error_select = s.trim.dither[cvt_pkg::DITH_ERR_BIT];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // The release edge itself still samples reset low, so it must not start an attempt
   a_fuse_copy: assert property (
      (presetn && !s.loaded) |=> (s.trim == $past(fuse_trim)) && s.loaded)
      else $error("trims not taken from fuses");

   a_index_home: assert property (
      !s.cal_en |-> (s.index == cvt_pkg::INDEX_FIRST))
      else $error("index not at first byte while disabled");

   a_index_step: assert property (
      (done && is_port && !s.pslverr && s.cal_en && pwrite == 1'b0
       && s.index != cvt_pkg::VEC_LAST)
      |=> (s.index == 10'($past(s.index) + 10'h001)))
      else $error("index did not advance on port read");

   a_index_wrap: assert property (
      (done && is_port && !s.pslverr && !pwrite && s.index == cvt_pkg::VEC_LAST)
      |=> (s.index == cvt_pkg::INDEX_FIRST))
      else $error("index did not wrap after last byte");

   a_port_refused: assert property (
      (psel && !penable && s.phase == cvt_pkg::PH_IDLE && is_port && !s.cal_en)
      |=> s.pready && s.pslverr && (s.prdata == 32'h0000_0000))
      else $error("disabled port access not refused");

   a_hold_fast: assert property (
      (psel && !penable && s.phase == cvt_pkg::PH_IDLE && is_port
       && s.cal_en && s.addr_hold) |=> s.pready)
      else $error("streaming port access was delayed");

   a_plain_wait: assert property (
      (psel && !penable && s.phase == cvt_pkg::PH_IDLE && is_port
       && s.cal_en && !s.addr_hold) |=> !s.pready ##1 s.pready)
      else $error("plain port access wait state wrong");

   a_ref_reserved: assert property (
      (s.phase == cvt_pkg::PH_ACK && idx == cvt_pkg::IDX_REFERENCE)
      |-> (s.prdata[31:4] == 28'h000_0000))
      else $error("reserved reference bits not zero");

   a_short_invalid: assert property (
      ($fell(s.cal_en) && $past(s.index) != cvt_pkg::INDEX_FIRST) |-> !s.valid)
      else $error("partial sequence left data valid");

   a_gain_write: assert property (
      (done && pwrite && pstrb[0] && !s.pslverr && idx == cvt_pkg::IDX_GAIN_A)
      |=> (s.trim.gain_a == $past(pwdata[7:0])))
      else $error("gain A write lost");

   a_dither_out: assert property (
      (done && pwrite && pstrb[0] && idx == cvt_pkg::IDX_DITHER)
      |=> (dither_enable_bit == $past(pwdata[0]))
          && (dither_amplitude_select == $past(pwdata[1])))
      else $error("dither outputs do not follow register");

   a_round_select: assert property (
      (done && pwrite && pstrb[0] && idx == cvt_pkg::IDX_DITHER)
      |=> (rounding_error_select == $past(pwdata[cvt_pkg::DITH_ERR_BIT])))
      else $error("rounding error select does not follow register");

   a_gain_b_write: assert property (
      (done && pwrite && pstrb[0] && !s.pslverr && idx == cvt_pkg::IDX_GAIN_B)
      |=> (s.trim.gain_b == $past(pwdata[7:0])))
      else $error("gain B write lost");

   a_ref_write: assert property (
      (done && pwrite && pstrb[0] && !s.pslverr && idx == cvt_pkg::IDX_REFERENCE)
      |=> (s.trim.ref_trim == $past(pwdata[3:0])))
      else $error("reference adjust write lost");

   a_term_a_write: assert property (
      (done && pwrite && pstrb[0] && !s.pslverr && idx == cvt_pkg::IDX_TERM_A)
      |=> (s.trim.term_a == $past(pwdata[7:0])))
      else $error("termination A write lost");

   a_term_b_write: assert property (
      (done && pwrite && pstrb[0] && !s.pslverr && idx == cvt_pkg::IDX_TERM_B)
      |=> (s.trim.term_b == $past(pwdata[7:0])))
      else $error("termination B write lost");

   // Only the last byte of a restore made while stopped may mark the data good
   a_restore_valid: assert property (
      (done && is_port && pwrite && !s.pslverr && s.stop_sync
       && s.index == cvt_pkg::VEC_LAST) |=> s.valid)
      else $error("full restore did not mark data valid");

   c_full_wrap: cover property (
      done && is_port && s.index == cvt_pkg::VEC_LAST && s.cal_en);
   c_restore_valid: cover property ($rose(s.valid));
   c_refused: cover property (s.pready && s.pslverr && is_port);
   c_stream: cover property (done && is_port && s.addr_hold ##1 psel && !penable);

endmodule

// file: cvt_pkg.sv
// Constants, field layouts and carrier types of the calibration vector and trim bank.
// Assumes a 100 MHz APB clock and a 12-bit byte address; each register is one word.
package cvt_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int INDEX_W = 10;
   localparam int VEC_LEN = 673;
   localparam logic [9:0] VEC_LAST = 10'(VEC_LEN - 1);
   localparam logic [9:0] INDEX_FIRST = 10'h000;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_ACCESS_OPTIONS = 10'h010;
   localparam logic [9:0] IDX_CAL_STATUS = 10'h011;
   localparam logic [9:0] IDX_CAL_ENABLE = 10'h070;
   localparam logic [9:0] IDX_CAL_PORT = 10'h071;
   localparam logic [9:0] IDX_GAIN_A = 10'h07A;
   localparam logic [9:0] IDX_GAIN_B = 10'h07B;
   localparam logic [9:0] IDX_REFERENCE = 10'h07C;
   localparam logic [9:0] IDX_TERM_A = 10'h07E;
   localparam logic [9:0] IDX_TERM_B = 10'h07F;
   localparam logic [9:0] IDX_DITHER = 10'h09D;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ENABLE_BIT = 0;
   localparam int HOLD_BIT = 0;
   localparam int DITH_EN_BIT = 0;
   localparam int DITH_AMP_BIT = 1;
   localparam int DITH_ERR_BIT = 2;
   localparam int STAT_STOP_BIT = 0;
   localparam int STAT_VALID_BIT = 1;
   localparam int STAT_INDEX_LSB = 16;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] gain_a;
      logic [7:0] gain_b;
      logic [3:0] ref_trim;
      logic [7:0] term_a;
      logic [7:0] term_b;
      logic [2:0] dither;
   } cvt_trim_type;

   // Values held only until the fuse copy lands one edge after reset
   localparam cvt_trim_type TRIM_RESET = '{8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 3'h1};

   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_WAIT = 3'b010,
      PH_ACK = 3'b100
   } cvt_phase_type;

   typedef struct packed {
      cvt_phase_type phase;
      cvt_trim_type trim;
      logic cal_en;
      logic addr_hold;
      logic valid;
      logic loaded;
      logic stop_meta;
      logic stop_sync;
      logic pready;
      logic pslverr;
      logic [9:0] index;
      logic [31:0] prdata;
   } cvt_state_type;

endpackage

// file: cvt_cal_store.sv
// Byte store that holds the calibration vector.
// Assumes one writer on pclk; read is combinational on the shared address.
`timescale 1ns/1ps
module cvt_cal_store #(
   parameter int DEPTH = 673,
   parameter int AW = 10
) (
   // Clock
   input wire logic pclk,
   // Access
   input wire logic wr_en,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   logic [7:0] mem [DEPTH];

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // No reset: contents are undefined until a full restore is written
   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
   end

   // Address stays below DEPTH because the index wraps at the last byte
   assign rdata = mem[addr];

endmodule

// file: test_cal_vector_and_trim_regs.sv
// Self-checking bench for the calibration vector port, trim bank and dither control.
// Assumes cvt_pkg is compiled first; the bench acts as APB master, fuse source and engine.
`timescale 1ns/1ps
module test_cal_vector_and_trim_regs;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [cvt_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   cvt_pkg::cvt_trim_type fuse_trim, trim_out;
   logic calibration_stopped_indication, cal_access_enabled, cal_data_valid;
   logic dither_enable_bit, dither_amplitude_select, rounding_error_select;
   int n_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int waits = 0;
   logic [7:0] vec [cvt_pkg::VEC_LEN];
   logic [9:0] tidx [6] = '{cvt_pkg::IDX_GAIN_A, cvt_pkg::IDX_GAIN_B, cvt_pkg::IDX_REFERENCE,
                            cvt_pkg::IDX_TERM_A, cvt_pkg::IDX_TERM_B, cvt_pkg::IDX_DITHER};
   logic [31:0] tmask [6] = '{32'hFF, 32'hFF, 32'h0F, 32'hFF, 32'hFF, 32'h07};

   cvt_regs cvt_regs_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fuse_trim(fuse_trim),
      .calibration_stopped_indication(calibration_stopped_indication),
      .cal_access_enabled(cal_access_enabled), .cal_data_valid(cal_data_valid),
      .trim_out(trim_out), .dither_enable_bit(dither_enable_bit),
      .dither_amplitude_select(dither_amplitude_select),
      .rounding_error_select(rounding_error_select)
   );

   // ------------------------------------------------------------
   // Clock and hang guard
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Whole run needs about 7000 cycles; the ceiling leaves ample slack
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_errors++;
         results();
      end
   end

   // ------------------------------------------------------------
   // Tasks and expectations
   // ------------------------------------------------------------
   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      waits = 0;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         waits++;
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] wd, input logic exp_err);
      logic [31:0] d;
      logic e;
      apb(1'b1, idx, wd, d, e);
      chk("write error flag", 64'(exp_err), 64'(e));
   endtask

   task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp,
                         input logic exp_err);
      logic [31:0] d;
      logic e;
      apb(1'b0, idx, 32'h0, d, e);
      chk(what, 64'(exp), 64'(d));
      chk("read error flag", 64'(exp_err), 64'(e));
   endtask

   // Full restore: every byte of the vector written once, in order
   task automatic write_vector();
      for (int k = 0; k < cvt_pkg::VEC_LEN; k++) begin
         vec[k] = 8'($urandom);
         wr(cvt_pkg::IDX_CAL_PORT, {24'h000000, vec[k]}, 1'b0);
      end
   endtask

   function automatic logic [31:0] fuse_word(input int k);
      case (k)
         0: return {24'h000000, fuse_trim.gain_a};
         1: return {24'h000000, fuse_trim.gain_b};
         2: return {28'h0000000, fuse_trim.ref_trim};
         3: return {24'h000000, fuse_trim.term_a};
         4: return {24'h000000, fuse_trim.term_b};
         default: return {29'h00000000, fuse_trim.dither};
      endcase
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [63:0] r;
      logic [31:0] w;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      presetn = 1'b0;
      calibration_stopped_indication = 1'b0;
      void'($urandom(32'h6DA50F0D));
      r = {$urandom, $urandom};
      fuse_trim = r[38:0];
      repeat (4) @(posedge pclk);
      chk("trim_out in reset", 64'(cvt_pkg::TRIM_RESET), 64'(trim_out));
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("trim_out after load", 64'(fuse_trim), 64'(trim_out));
      chk("dither outputs", 64'(fuse_trim.dither), 64'({rounding_error_select,
          dither_amplitude_select, dither_enable_bit}));
      for (int k = 0; k < 6; k++)
         rd_chk("fuse reset value", tidx[k], fuse_word(k), 1'b0);
      // Trims read back only their implemented bits
      for (int k = 0; k < 5; k++) begin
         w = $urandom;
         wr(tidx[k], w, 1'b0);
         rd_chk("trim readback", tidx[k], w & tmask[k], 1'b0);
      end
      // Every dither code, reserved bits driven high to prove they are dropped
      for (int k = 0; k < 8; k++) begin
         wr(cvt_pkg::IDX_DITHER, ($urandom | 32'hF8) & ~32'h7 | k, 1'b0);
         rd_chk("dither readback", cvt_pkg::IDX_DITHER, k, 1'b0);
         @(negedge pclk);
         chk("dither bits", 64'(k), 64'({rounding_error_select, dither_amplitude_select,
             dither_enable_bit}));
      end
      rd_chk("unmapped read", 10'h3FF, 32'h0, 1'b1);
      wr(10'h3FF, 32'hFFFFFFFF, 1'b1);
      // Port refused while access enable is clear; the index must not move
      calibration_stopped_indication <= 1'b1;
      rd_chk("port while disabled", cvt_pkg::IDX_CAL_PORT, 32'h0, 1'b1);
      wr(cvt_pkg::IDX_CAL_PORT, 32'h5A, 1'b1);
      wr(cvt_pkg::IDX_CAL_ENABLE, 32'h1, 1'b0);
      rd_chk("status idle", cvt_pkg::IDX_CAL_STATUS, 32'h1, 1'b0);
      chk("access enabled", 64'h1, 64'(cal_access_enabled));
      write_vector();
      chk("wait states without hold", 64'd1, 64'(waits));
      @(negedge pclk);
      chk("valid after full restore", 64'h1, 64'(cal_data_valid));
      rd_chk("status wrapped", cvt_pkg::IDX_CAL_STATUS, 32'h3, 1'b0);
      // Streaming readout at one address with the hold option
      wr(cvt_pkg::IDX_ACCESS_OPTIONS, 32'h1, 1'b0);
      for (int k = 0; k < cvt_pkg::VEC_LEN; k++)
         rd_chk("vector byte", cvt_pkg::IDX_CAL_PORT, {24'h0, vec[k]}, 1'b0);
      chk("wait states with hold", 64'd0, 64'(waits));
      @(negedge pclk);
      chk("valid after readout", 64'h1, 64'(cal_data_valid));
      // Reads alone keep the data good, but an abandoned readout must spoil it
      for (int k = 0; k < 3; k++)
         rd_chk("partial readout", cvt_pkg::IDX_CAL_PORT, {24'h0, vec[k]}, 1'b0);
      wr(cvt_pkg::IDX_CAL_ENABLE, 32'h0, 1'b0);
      rd_chk("status abandoned", cvt_pkg::IDX_CAL_STATUS, 32'h1, 1'b0);
      wr(cvt_pkg::IDX_CAL_ENABLE, 32'h1, 1'b0);
      // Short restore leaves the data invalid; clearing enable rewinds the index
      for (int k = 0; k < 5; k++) begin
         vec[k] = 8'($urandom);
         wr(cvt_pkg::IDX_CAL_PORT, {24'h0, vec[k]}, 1'b0);
      end
      rd_chk("status partial", cvt_pkg::IDX_CAL_STATUS, 32'h00050001, 1'b0);
      wr(cvt_pkg::IDX_CAL_ENABLE, 32'h0, 1'b0);
      rd_chk("status rewound", cvt_pkg::IDX_CAL_STATUS, 32'h1, 1'b0);
      chk("access disabled", 64'h0, 64'(cal_access_enabled));
      wr(cvt_pkg::IDX_CAL_ENABLE, 32'h1, 1'b0);
      rd_chk("first byte again", cvt_pkg::IDX_CAL_PORT, {24'h0, vec[0]}, 1'b0);
      rd_chk("second byte again", cvt_pkg::IDX_CAL_PORT, {24'h0, vec[1]}, 1'b0);
      // Valid restore, then a port access while calibration runs spoils it
      wr(cvt_pkg::IDX_CAL_ENABLE, 32'h0, 1'b0);
      wr(cvt_pkg::IDX_CAL_ENABLE, 32'h1, 1'b0);
      write_vector();
      @(negedge pclk);
      chk("valid before running access", 64'h1, 64'(cal_data_valid));
      calibration_stopped_indication <= 1'b0;
      repeat (4) @(posedge pclk);
      wr(cvt_pkg::IDX_CAL_PORT, 32'h0, 1'b0);
      @(negedge pclk);
      chk("valid after running access", 64'h0, 64'(cal_data_valid));
      results();
   end
endmodule
